/* src/sdam_top.sv */
// Address mapper top: field split, open-row tracking and access command choice.
`timescale 1ns/1ps
`default_nettype none
module sdam_top
(
	input  wire logic                          clk,
	input  wire logic                          nrst,
	input  wire logic                          ce,
	input  wire sdam_pkg::sdam_cfg_t           cfg,
	input  wire logic                          req_valid,
	input  wire logic [sdam_pkg::ADDR_W-1:0]   req_addr,
	input  wire logic                          req_write,
	input  wire logic                          seq_done,
	output logic                               req_ready,
	output sdam_pkg::sdam_cmd_t                cmd_q,
	output logic                               cmd_write_q,
	output sdam_pkg::sdam_fields_t             fields_q,
	output logic                               bank_select_pin_high,
	output logic                               bank_select_pin_low,
	output logic [sdam_pkg::NBANKS-1:0]        row_open_q
);
	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic rst_meta_q;
	logic rst_sync_q;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end
	wire logic rst_n = rst_sync_q;

	// ----------------------------------------
	// Field split, same cycle as the request
	// ----------------------------------------
	sdam_pkg::sdam_fields_t split;
	sdam_split u_split
	(
		.addr   (req_addr),
		.cfg    (cfg),
		.fields (split)
	);                                                                        // [RULE_11]

	// ----------------------------------------
	// Sequencer handshake states
	// ----------------------------------------
	typedef enum logic [3:0] {
		SDAM_IDLE = 4'b0001,
		SDAM_PRE  = 4'b0010,
		SDAM_ACT  = 4'b0100,
		SDAM_ACC  = 4'b1000
	} sdam_state_t;
	sdam_state_t state_q;
	logic [sdam_pkg::ROW_W-1:0] open_row_q [sdam_pkg::NBANKS];
	logic hit;
	logic was_open;
	logic ready_q;
	assign req_ready = ready_q;
	assign was_open = row_open_q[split.bank];
	assign hit = was_open && (open_row_q[split.bank] == split.row);          // [RULE_09]

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q     <= SDAM_IDLE;
			cmd_q       <= sdam_pkg::SDAM_CMD_NONE;
			cmd_write_q <= 1'b0;
			fields_q    <= '0;
			ready_q     <= 1'b0;
		end
		else if (ce)
		begin
			case (state_q)
				SDAM_IDLE:
				begin
					ready_q <= 1'b1;
					cmd_q   <= sdam_pkg::SDAM_CMD_NONE;
					if (req_valid && ready_q)                              // [RULE_01]
					begin
						ready_q     <= 1'b0;
						fields_q    <= split;
						cmd_write_q <= req_write;
						if (hit)
						begin
							cmd_q   <= sdam_pkg::SDAM_CMD_ACCESS;           // [RULE_09]
							state_q <= SDAM_ACC;
						end
						else if (was_open)
						begin
							cmd_q   <= sdam_pkg::SDAM_CMD_PRE;              // [RULE_10]
							state_q <= SDAM_PRE;
						end
						else
						begin
							cmd_q   <= sdam_pkg::SDAM_CMD_ACT;
							state_q <= SDAM_ACT;
						end
					end
				end
				SDAM_PRE:
					if (seq_done)
					begin
						cmd_q   <= sdam_pkg::SDAM_CMD_ACT;                  // [RULE_10]
						state_q <= SDAM_ACT;
					end
				SDAM_ACT:
					if (seq_done)
					begin
						cmd_q   <= sdam_pkg::SDAM_CMD_ACCESS;               // [RULE_10]
						state_q <= SDAM_ACC;
					end
				SDAM_ACC:
					if (seq_done)
					begin
						cmd_q   <= sdam_pkg::SDAM_CMD_NONE;
						state_q <= SDAM_IDLE;
					end
				default:
					state_q <= SDAM_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Open row table
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			row_open_q <= '0;
		else if (ce && state_q == SDAM_ACT && seq_done)
			row_open_q[fields_q.bank] <= 1'b1;                                // [RULE_09]
	end

	// Row values need no reset: the valid bits gate them
	always_ff @(posedge clk)
	begin
		if (ce && state_q == SDAM_ACT && seq_done)
			open_row_q[fields_q.bank] <= fields_q.row;                        // [RULE_09]
	end

	// ----------------------------------------
	// Bank select pins
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bank_select_pin_high <= 1'b0;
			bank_select_pin_low  <= 1'b0;
		end
		else if (ce)
		begin
			bank_select_pin_high <= fields_q.bank[1];                         // [RULE_08]
			bank_select_pin_low  <= fields_q.bank[0];                         // [RULE_08]
		end
	end
endmodule
`default_nettype wire

/* src/sdam_pkg.sv */
// Constants and carrier types for the SDRAM address mapper.
// Summary of operation
// (RULE_01) Host accesses become SDRAM command sequences; software sees linear memory.
// (RULE_02) 32-bit bus: address bits 1:0 are byte offset, not column.
// (RULE_03) 32-bit bus: column from bit 2, 8 to 11 bits; row, bank above.
// (RULE_04) 16-bit bus: bit 0 is byte offset; column from bit 1, row, bank above.
// (RULE_05) 2K rows: 11-bit row taken just above the column field.
// (RULE_06) 4K rows: 12-bit row above column; bank moves up one bit.
// (RULE_07) 8K rows: 13-bit row; 2048 columns on 32-bit puts bank at 27:26.
// (RULE_08) Upper bank bit drives bank select pin 1, lower drives pin 0.
// (RULE_09) Open row per bank is remembered; hits need no activate.
// (RULE_10) Row miss or boundary: precharge, activate, then read or write.
// (RULE_11) Split chosen from static config inputs, applied without extra latency.
`default_nettype none
package sdam_pkg;

	localparam int ADDR_W    = 28;
	localparam int ROW_W     = 13;
	localparam int COL_W     = 11;
	localparam int BANK_W    = 2;
	localparam int NBANKS    = 4;
	localparam int COL_BASE  = 8;
	localparam int ROW_BASE  = 11;

	localparam logic [1:0] ROWS_2K = 2'h0;
	localparam logic [1:0] ROWS_4K = 2'h1;
	localparam logic [1:0] ROWS_8K = 2'h2;
	localparam logic [1:0] COLS_256  = 2'h0;
	localparam logic [1:0] COLS_2048 = 2'h3;

	localparam logic [4:0] OFS32_W = 5'h2;
	localparam logic [4:0] OFS16_W = 5'h1;

	// Command codes toward the sequencer
	typedef enum logic [2:0] {
		SDAM_CMD_NONE   = 3'h0,
		SDAM_CMD_ACCESS = 3'h1,
		SDAM_CMD_ACT    = 3'h2,
		SDAM_CMD_PRE    = 3'h3
	} sdam_cmd_t;

	typedef struct packed {
		logic              bus16;
		logic [1:0]        rows;
		logic [1:0]        cols;
	} sdam_cfg_t;

	typedef struct packed {
		logic [BANK_W-1:0] bank;
		logic [ROW_W-1:0]  row;
		logic [COL_W-1:0]  col;
		logic [1:0]        byte_ofs;
	} sdam_fields_t;

endpackage
`default_nettype wire

/* src/sdam_split.sv */
// Combinational split of a CPU address into bank, row, column and byte offset.
`timescale 1ns/1ps
`default_nettype none
module sdam_split
(
	input  wire logic [sdam_pkg::ADDR_W-1:0] addr,
	input  wire sdam_pkg::sdam_cfg_t         cfg,
	output var  sdam_pkg::sdam_fields_t      fields
);
	logic [4:0] ofs_w;
	logic [4:0] col_w;
	logic [4:0] row_w;
	logic [4:0] row_lo;
	logic [4:0] bank_lo;
	logic [sdam_pkg::ADDR_W-1:0] shr;

	always_comb
	begin
		ofs_w   = cfg.bus16 ? sdam_pkg::OFS16_W : sdam_pkg::OFS32_W;         // [RULE_02] [RULE_04]
		col_w   = 5'(sdam_pkg::COL_BASE) + {3'h0, cfg.cols};                 // [RULE_03]
		row_w   = 5'(sdam_pkg::ROW_BASE) + {3'h0, cfg.rows};   // [RULE_05] [RULE_06] [RULE_07]
		row_lo  = ofs_w + col_w;
		bank_lo = row_lo + row_w;
		fields  = '0;
		fields.byte_ofs = cfg.bus16 ? {1'b0, addr[0]} : addr[1:0];
		shr = addr >> ofs_w;
		for (int i = 0; i < sdam_pkg::COL_W; i++)
			fields.col[i] = (5'(i) < col_w) ? shr[i] : 1'b0;
		shr = addr >> row_lo;
		for (int i = 0; i < sdam_pkg::ROW_W; i++)
			fields.row[i] = (5'(i) < row_w) ? shr[i] : 1'b0;
		shr = addr >> bank_lo;
		fields.bank = shr[sdam_pkg::BANK_W-1:0];                             // [RULE_07]
	end
endmodule
`default_nettype wire

/* tb/sdam_monitor.sv */
// Concurrent checks on the address mapper ports.
`timescale 1ns/1ps
`default_nettype none
module sdam_monitor
(
	input wire logic                   clk,
	input wire logic                   nrst,
	input wire logic                   ce,
	input wire sdam_pkg::sdam_cfg_t    cfg,
	input wire logic                   req_valid,
	input wire logic [27:0]            req_addr,
	input wire logic                   seq_done,
	input wire logic                   req_ready,
	input wire sdam_pkg::sdam_cmd_t    cmd_q,
	input wire sdam_pkg::sdam_fields_t fields_q,
	input wire logic                   bank_select_pin_high,
	input wire logic                   bank_select_pin_low,
	input wire logic [3:0]             row_open_q
);
	logic tk;
	assign tk = ce && req_valid && req_ready;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	a_bank_pin_follow:
	assert property ($past(ce) |-> {bank_select_pin_high, bank_select_pin_low}
		== $past(fields_q.bank)) else $error("bank pins");
	a_take_starts_cmd:
	assert property (tk |=> cmd_q != sdam_pkg::SDAM_CMD_NONE && !req_ready) else $error("take");
	a_cmd_stands:
	assert property (ce && cmd_q != sdam_pkg::SDAM_CMD_NONE && !seq_done
		|=> $stable(cmd_q) && $stable(fields_q)) else $error("cmd held");
	a_pre_then_act:
	assert property (ce && cmd_q == sdam_pkg::SDAM_CMD_PRE && seq_done
		|=> cmd_q == sdam_pkg::SDAM_CMD_ACT) else $error("pre order");
	a_act_opens_row:
	assert property (ce && cmd_q == sdam_pkg::SDAM_CMD_ACT && seq_done
		|=> cmd_q == sdam_pkg::SDAM_CMD_ACCESS && row_open_q[fields_q.bank]) else $error("act");
	a_access_ends:
	assert property (ce && cmd_q == sdam_pkg::SDAM_CMD_ACCESS && seq_done
		|=> cmd_q == sdam_pkg::SDAM_CMD_NONE ##1 req_ready) else $error("end");
	a_byte_offset:
	assert property (tk |=> fields_q.byte_ofs == ($past(cfg.bus16)
		? {1'b0, $past(req_addr[0])} : $past(req_addr[1:0]))) else $error("offset");
	a_column_base:
	assert property (tk |=> fields_q.col[0] == ($past(cfg.bus16)
		? $past(req_addr[1]) : $past(req_addr[2]))) else $error("column");
	cover property (cmd_q == sdam_pkg::SDAM_CMD_PRE && seq_done);
	cover property (tk && cfg.bus16);
	cover property (tk && cfg.rows == sdam_pkg::ROWS_8K && cfg.cols == sdam_pkg::COLS_2048);
	cover property (!ce && req_valid && req_ready);
endmodule
bind sdam_top sdam_monitor sdam_monitor_inst
(
	.clk                  (clk),
	.nrst                 (nrst),
	.ce                   (ce),
	.cfg                  (cfg),
	.req_valid            (req_valid),
	.req_addr             (req_addr),
	.seq_done             (seq_done),
	.req_ready            (req_ready),
	.cmd_q                (cmd_q),
	.fields_q             (fields_q),
	.bank_select_pin_high (bank_select_pin_high),
	.bank_select_pin_low  (bank_select_pin_low),
	.row_open_q           (row_open_q)
);
`default_nettype wire

/* tb/sdam_seq_model.sv */
// Sequencer stand-in: acknowledges each step after lat extra cycles.
`timescale 1ns/1ps
`default_nettype none
module sdam_seq_model
(
	input wire logic                clk,
	input wire logic                nrst,
	input wire sdam_pkg::sdam_cmd_t cmd_q,
	input wire logic [1:0]          lat,
	output logic                    seq_done
);
	logic [1:0] cnt_q;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cnt_q <= 2'h0;
			seq_done <= 1'b0;
		end
		else
		begin
			seq_done <= !seq_done && cmd_q != sdam_pkg::SDAM_CMD_NONE && cnt_q == lat;
			cnt_q <= (seq_done || cmd_q == sdam_pkg::SDAM_CMD_NONE || cnt_q == lat)
				? 2'h0 : cnt_q + 2'h1;
		end
	end
endmodule
`default_nettype wire

/* tb/sdam_top_test.sv */
// Self-checking bench for the address mapper with a sequencer stand-in.
`timescale 1ns/1ps
`default_nettype none
module sdam_top_test;
	logic                   clk = 0, nrst = 0, ce = 1, req_valid = 0, req_write = 0;
	logic [27:0]            req_addr = 28'h0;
	logic [1:0]             lat = 2'h0;
	sdam_pkg::sdam_cfg_t    cfg = '0;
	logic                   seq_done, req_ready, cmd_write_q;
	logic                   bank_select_pin_high, bank_select_pin_low;
	logic [3:0]             row_open_q;
	sdam_pkg::sdam_cmd_t    cmd_q;
	sdam_pkg::sdam_fields_t fields_q;
	int                     miscompares = 0, cmp_count = 0, orow[4];
	bit                     oval[4];
	sdam_top sdam_top_inst
	(
		.clk                  (clk),
		.nrst                 (nrst),
		.ce                   (ce),
		.cfg                  (cfg),
		.req_valid            (req_valid),
		.req_addr             (req_addr),
		.req_write            (req_write),
		.seq_done             (seq_done),
		.req_ready            (req_ready),
		.cmd_q                (cmd_q),
		.cmd_write_q          (cmd_write_q),
		.fields_q             (fields_q),
		.bank_select_pin_high (bank_select_pin_high),
		.bank_select_pin_low  (bank_select_pin_low),
		.row_open_q           (row_open_q)
	);
	sdam_seq_model sdam_seq_model_inst
	(
		.clk      (clk),
		.nrst     (nrst),
		.cmd_q    (cmd_q),
		.lat      (lat),
		.seq_done (seq_done)
	);
	initial forever #25 clk = ~clk;
	task chk(input bit ok, input string m);
		cmp_count++;
		if (!ok)
		begin
			miscompares++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task print_verdict;
		if (miscompares == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk_reset;
		chk(req_ready === 1'b0 && cmd_q === sdam_pkg::SDAM_CMD_NONE && row_open_q === 4'h0
			&& fields_q === '0 && {bank_select_pin_high, bank_select_pin_low} === 2'h0,
			"reset");
	endtask
	task req(input int a);
		int ow, cw, rw, bk, row, hold;
		sdam_pkg::sdam_cmd_t ec;
		logic wr;
		ow = cfg.bus16 ? 1 : 2;
		cw = 8 + cfg.cols;
		rw = 11 + cfg.rows;
		row = (a >> (ow + cw)) & ((1 << rw) - 1);
		bk = (a >> (ow + cw + rw)) & 3;
		ec = !oval[bk] ? sdam_pkg::SDAM_CMD_ACT : orow[bk] == row
			? sdam_pkg::SDAM_CMD_ACCESS : sdam_pkg::SDAM_CMD_PRE;
		wr = 1'($urandom);
		lat = 2'($urandom);
		hold = 1 + int'($urandom % 3);
		repeat (100) if (req_ready !== 1'b1) @(posedge clk) #1;
		chk(req_ready === 1'b1, "ready timeout");
		req_valid = 1;
		req_addr = 28'(a);
		req_write = wr;
		// Request offered while the enable is low must not be taken
		ce = 0;
		repeat (hold) @(posedge clk) #1;
		chk(req_ready === 1'b1 && cmd_q === sdam_pkg::SDAM_CMD_NONE, "frozen");
		ce = 1;
		@(posedge clk) #1;
		req_valid = 0;
		chk(cmd_q === ec && cmd_write_q === wr, "first cmd");
		chk(fields_q === {2'(bk), 13'(row), 11'((a >> ow) & ((1 << cw) - 1)),
			2'(a & ((1 << ow) - 1))}, "split");
		@(posedge clk) #1;
		chk({bank_select_pin_high, bank_select_pin_low} === 2'(bk), "pins");
		repeat (100) if (req_ready !== 1'b1) @(posedge clk) #1;
		chk(row_open_q[bk] === 1'b1 && cmd_q === sdam_pkg::SDAM_CMD_NONE, "open");
		oval[bk] = 1;
		orow[bk] = row;
	endtask
	initial
	begin
		#2000000;
		miscompares++;
		print_verdict;
	end
	initial
	begin
		int a;
		void'($urandom(32'h3C2A));
		repeat (20) @(posedge clk) #1;
		chk_reset;
		nrst = 1;
		// Every bus width, row count and column count
		for (int m = 0; m < 24; m++)
		begin
			// Mid-run reset empties the open-row table
			if (m == 12)
			begin
				nrst = 0;
				@(posedge clk) #1;
				chk_reset;
				nrst = 1;
				oval = '{default: 1'b0};
			end
			cfg = sdam_pkg::sdam_cfg_t'({m[0], 2'(m / 8), 2'(m / 2 % 4)});
			a = $urandom & 32'h0FFFFFFF;
			req(a);
			req(a ^ 4);
			req(a ^ (1 << ((cfg.bus16 ? 9 : 10) + cfg.cols)));
			req($urandom & 32'h0FFFFFFF);
		end
		print_verdict;
	end
endmodule
`default_nettype wire
